//--- lcdp_pkg.sv
// package: constants for the lcd driver two-wire command port
package lcdp_pkg;
   localparam logic [5:0] LCDP_ADDR_HI      = 6'h1C;
   localparam int         LCDP_CONT_BIT     = 7;
   localparam int         LCDP_ROUTE_BIT    = 6;
   localparam logic [3:0] LCDP_OP_MODE      = 4'hC;
   localparam logic [3:0] LCDP_OP_PTR_HI    = 4'h0;
   localparam logic [3:0] LCDP_OP_PTR_LO    = 4'h4;
   localparam logic [5:0] LCDP_OP_DEVSEL    = 6'h38;
   localparam logic [5:0] LCDP_OP_BANK      = 6'h3E;
   localparam logic [4:0] LCDP_OP_BLINK     = 5'h1E;
   localparam logic [4:0] LCDP_OP_PRESC     = 5'h1D;
   localparam int         LCDP_MODE_E_BIT   = 3;
   localparam int         LCDP_MODE_B_BIT   = 2;
   localparam logic [1:0] LCDP_DRV_STATIC   = 2'h1;
   localparam logic [1:0] LCDP_DRV_MUX2     = 2'h2;
   localparam logic [1:0] LCDP_DRV_MUX3     = 2'h3;
   localparam logic [1:0] LCDP_DRV_MUX4     = 2'h0;
   localparam logic [7:0] LCDP_PTR_LAST     = 8'h9F;
   localparam logic [7:0] LCDP_PTR_RST      = 8'h00;
   localparam logic [1:0] LCDP_SUB_RST      = 2'h0;
   localparam logic [2:0] LCDP_BIT_LAST     = 3'h7;
   localparam logic [2:0] LCDP_BLINK_RST    = 3'h0;
   localparam logic [2:0] LCDP_PRESC_RST    = 3'h3;
   localparam logic [1:0] LCDP_BANK_RST     = 2'h0;
   typedef enum logic [2:0] {
      LCDP_IDLE = 3'h0,
      LCDP_ADDR = 3'h1,
      LCDP_CTRL = 3'h3,
      LCDP_BODY = 3'h2,
      LCDP_IGN  = 3'h6
   } lcdp_state_e;
endpackage

//--- lcdp_bus_if.sv
// interface: bit-level events from the bus front end to the decoder
`timescale 1ns/1ns
interface lcdp_bus_if;
   logic       start;
   logic       stop;
   logic       byte_done;
   logic [7:0] byte_val;
   logic       ack_slot;
   logic       ack_end;
   modport fe  (output start, output stop, output byte_done, output byte_val,
                output ack_slot, output ack_end);
   modport dec (input start, input stop, input byte_done, input byte_val,
                input ack_slot, input ack_end);
endinterface // lcdp_bus_if

//--- lcdp_frontend.sv
// module: two-wire start/stop detection and byte shifting
`timescale 1ns/1ns
module lcdp_frontend
   import lcdp_pkg::*;
(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_b,
   // bus lines
   input  wire logic scl_in,
   input  wire logic sda_in,
   // events
   lcdp_bus_if.fe    bus
);
   logic       scl_reg, sda_reg;
   logic [2:0] cnt_reg, cnt_next;
   logic [7:0] sh_reg;
   logic       ack_reg, ack_next;   // ninth clock, ack may be driven
   logic       wait_reg, wait_next; // eighth bit taken, scl not yet low
   logic       act_reg;
   wire        busy = wait_reg || ack_reg;
   wire scl_rise = scl_in && !scl_reg;
   wire scl_fall = !scl_in && scl_reg;
   wire start_w  = scl_in && scl_reg && sda_reg && !sda_in;
   wire stop_w   = scl_in && scl_reg && !sda_reg && sda_in;
   wire [7:0] sh_next = {sh_reg[6:0], sda_in};
   assign bus.start     = start_w;
   assign bus.stop      = stop_w;
   assign bus.byte_done = act_reg && !busy && scl_rise && (cnt_reg == LCDP_BIT_LAST);
   assign bus.byte_val  = sh_next;
   assign bus.ack_slot  = ack_reg;
   assign bus.ack_end   = ack_reg && scl_fall;
   // ack slot waits for scl low after the eighth bit: pulling sda while
   // scl is still high would look like a start to every receiver
   assign wait_next = (start_w || stop_w) ? 1'b0 :
                      bus.byte_done ? 1'b1 : (scl_fall ? 1'b0 : wait_reg);
   assign ack_next  = (start_w || stop_w) ? 1'b0 :
                      (wait_reg && scl_fall) ? 1'b1 : (bus.ack_end ? 1'b0 : ack_reg);
   assign cnt_next  = (start_w || stop_w) ? 3'h0 :
                      (act_reg && !busy && scl_rise) ? cnt_reg + 3'h1 : cnt_reg;
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         cnt_reg <= 3'h0;
         sh_reg  <= 8'h00;
         ack_reg <= 1'b0;
         wait_reg <= 1'b0;
         act_reg <= 1'b0;
      end else begin
         scl_reg <= scl_in;
         sda_reg <= sda_in;
         cnt_reg <= cnt_next;
         ack_reg <= ack_next;
         wait_reg <= wait_next;
         if (scl_rise && !busy)
            sh_reg <= sh_next;
         if (start_w)
            act_reg <= 1'b1;
         else if (stop_w)
            act_reg <= 1'b0;
      end
   end
endmodule // lcdp_frontend

//--- lcdp_top.sv
// module: write-only two-wire slave port and command decoder of a segment lcd driver
// How it works
// - slave receiver only; the acknowledge pull-down is the only output to the bus
// - address is 011100 plus the address strap level as the lowest bit
// - a read request gets no acknowledge and no data
// - matching devices ack together; a mismatch ignores all until stop or start
// - control byte bit 7 says whether another control byte follows
// - control byte bit 6 routes next byte to commands or display ram
// - every addressed device acks control and command bytes
// - display byte goes to pointer plus subaddress, then the pointer advances; the subaddress advances only when the pointer wraps
// - only the device whose straps equal the subaddress counter acks display bytes
// - decoder knows seven commands by their fixed upper opcode bits
// - mode bit 3 enables the display and the clock output, reset blank
// - mode bit 2 picks half bias when set, third bias at reset
// - mode bits 1:0 pick drive mode, reset is 1:4 multiplex
// - pointer-high loads the upper nibble of the data pointer, reset zero
// - pointer-low loads the lower nibble of the data pointer, reset zero
// - device-select copies its two low bits into the subaddress counter
// - bank-select ignored in 1:3 and 1:4 multiplex
`timescale 1ns/1ns
module lcdp_top
   import lcdp_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   // bus lines and acknowledge output
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_ack_out,
   output logic            sda_ack_oe,
   // straps
   input  wire logic       addr_lsb_strap,
   input  wire logic       subaddr_strap_bit0,
   input  wire logic       subaddr_strap_bit1,
   // configuration outputs
   output logic            display_enable,
   output logic            clk_out_enable,
   output logic            bias_half,
   output logic [1:0]      drive_mode,
   output logic [7:0]      data_pointer,
   output logic [1:0]      subaddr_count,
   output logic [1:0]      bank_sel,
   output logic [2:0]      blink_sel,
   output logic [2:0]      presc_sel,
   // display ram write port
   output logic            ram_we,
   output logic [7:0]      ram_addr,
   output logic [7:0]      ram_data
);
   // ==========================================================
   // front end
   lcdp_bus_if bus ();
   lcdp_frontend u_fe (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .scl_in  (scl_in),
      .sda_in  (sda_in),
      .bus     (bus)
   );

   // ==========================================================
   // state
   lcdp_state_e st_reg, st_next;
   logic        cont_reg, cont_next;      // another control byte pending
   logic        route_reg, route_next;    // 1: display ram
   logic        last_reg, last_next;      // final control byte seen
   logic        ack_reg, ack_next;
   logic [3:0]  mode_reg;
   logic [7:0]  ptr_reg;
   logic [1:0]  sub_reg;
   logic [1:0]  bank_reg;
   logic [2:0]  blink_reg;
   logic [2:0]  presc_reg;
   logic        we_reg;
   logic [7:0]  wa_reg, wd_reg;

   wire [7:0] b          = bus.byte_val;
   wire       addr_match = (b[7:2] == LCDP_ADDR_HI) && (b[1] == addr_lsb_strap);
   wire       is_write   = !b[0];
   wire [1:0] strap_sub  = {subaddr_strap_bit1, subaddr_strap_bit0};
   wire       sub_hit    = (sub_reg == strap_sub);
   wire       in_addr    = (st_reg == LCDP_ADDR);
   wire       in_ctrl    = (st_reg == LCDP_CTRL);
   wire       in_body    = (st_reg == LCDP_BODY);
   wire       got        = bus.byte_done;
   wire       cmd_byte   = got && in_body && !route_reg;
   wire       dat_byte   = got && in_body && route_reg;

   // ==========================================================
   // command decode
   wire op_mode   = cmd_byte && (b[7:4] == LCDP_OP_MODE);
   wire op_ptr_hi = cmd_byte && (b[7:4] == LCDP_OP_PTR_HI);
   wire op_ptr_lo = cmd_byte && (b[7:4] == LCDP_OP_PTR_LO);
   wire op_devsel = cmd_byte && (b[7:2] == LCDP_OP_DEVSEL);
   wire op_bank   = cmd_byte && (b[7:2] == LCDP_OP_BANK);
   wire op_blink  = cmd_byte && (b[7:3] == LCDP_OP_BLINK);
   wire op_presc  = cmd_byte && (b[7:3] == LCDP_OP_PRESC);
   wire mux_hi    = (mode_reg[1:0] == LCDP_DRV_MUX3) || (mode_reg[1:0] == LCDP_DRV_MUX4);
   wire bank_ok   = op_bank && !mux_hi;

   // pointer wraps past the last location and hands over to the next subaddress
   wire       ptr_wrap = (ptr_reg == LCDP_PTR_LAST);
   wire [7:0] ptr_inc  = ptr_wrap ? LCDP_PTR_RST : ptr_reg + 8'h01;
   wire [1:0] sub_inc  = ptr_wrap ? sub_reg + 2'h1 : sub_reg;

   // ==========================================================
   // byte sequencing
   always_comb begin
      st_next    = st_reg;
      cont_next  = cont_reg;
      route_next = route_reg;
      last_next  = last_reg;
      ack_next   = bus.ack_end ? 1'b0 : ack_reg;
      case (st_reg)
         LCDP_IDLE: ;
         LCDP_ADDR: if (got) begin
            if (addr_match && is_write) begin
               st_next  = LCDP_CTRL;
               ack_next = 1'b1;
            end else begin
               st_next  = LCDP_IGN;
            end
         end
         LCDP_CTRL: if (got) begin
            cont_next  = b[LCDP_CONT_BIT];
            route_next = b[LCDP_ROUTE_BIT];
            last_next  = !b[LCDP_CONT_BIT];
            ack_next   = 1'b1;
            st_next    = LCDP_BODY;
         end
         LCDP_BODY: if (got) begin
            // display bytes: only selected subaddress; commands: everyone
            ack_next = route_reg ? sub_hit : 1'b1;
            if (!last_reg && cont_reg)
               st_next = LCDP_CTRL;
            else
               st_next = LCDP_BODY;
         end
         LCDP_IGN: ;
         default: st_next = LCDP_IDLE;
      endcase
      if (bus.start) begin
         st_next   = LCDP_ADDR;
         last_next = 1'b0;
         ack_next  = 1'b0;
      end else if (bus.stop) begin
         st_next   = LCDP_IDLE;
         last_next = 1'b0;
         ack_next  = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         st_reg    <= LCDP_IDLE;
         cont_reg  <= 1'b0;
         route_reg <= 1'b0;
         last_reg  <= 1'b0;
         ack_reg   <= 1'b0;
      end else begin
         st_reg    <= st_next;
         cont_reg  <= cont_next;
         route_reg <= route_next;
         last_reg  <= last_next;
         ack_reg   <= ack_next;
      end
   end

   // ==========================================================
   // configuration and ram write; unknown opcodes fall through untouched
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         mode_reg  <= {2'h0, LCDP_DRV_MUX4};
         ptr_reg   <= LCDP_PTR_RST;
         sub_reg   <= LCDP_SUB_RST;
         bank_reg  <= LCDP_BANK_RST;
         blink_reg <= LCDP_BLINK_RST;
         presc_reg <= LCDP_PRESC_RST;
         we_reg    <= 1'b0;
         wa_reg    <= 8'h00;
         wd_reg    <= 8'h00;
      end else begin
         we_reg <= dat_byte && sub_hit;
         if (op_mode)
            mode_reg <= b[3:0];
         if (op_ptr_hi)
            ptr_reg[7:4] <= b[3:0];
         if (op_ptr_lo)
            ptr_reg[3:0] <= b[3:0];
         if (op_devsel)
            sub_reg <= b[1:0];
         if (bank_ok)
            bank_reg <= b[1:0];
         if (op_blink)
            blink_reg <= b[2:0];
         if (op_presc)
            presc_reg <= b[2:0];
         if (dat_byte) begin
            wa_reg  <= ptr_reg;
            wd_reg  <= b;
            ptr_reg <= ptr_inc;
            sub_reg <= sub_inc;
         end
      end
   end

   // ==========================================================
   // outputs; pull-down only during the ack slot
   assign sda_ack_oe     = ack_reg && bus.ack_slot;
   assign sda_ack_out    = 1'b0;
   assign display_enable = mode_reg[LCDP_MODE_E_BIT];
   assign clk_out_enable = mode_reg[LCDP_MODE_E_BIT];
   assign bias_half      = mode_reg[LCDP_MODE_B_BIT];
   assign drive_mode     = mode_reg[1:0];
   assign data_pointer   = ptr_reg;
   assign subaddr_count  = sub_reg;
   assign bank_sel       = bank_reg;
   assign blink_sel      = blink_reg;
   assign presc_sel      = presc_reg;
   assign ram_we         = we_reg;
   assign ram_addr       = wa_reg;
   assign ram_data       = wd_reg;

   // ==========================================================
   // checks
   a_read_no_ack: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (in_addr && got && !is_write) |=> !ack_reg)
      else $error("read access acknowledged");
   a_mismatch_ign: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (in_addr && got && !addr_match && !bus.start) |=> st_reg == LCDP_IGN)
      else $error("mismatched address not ignored");
   a_ctrl_ack: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (in_ctrl && got && !bus.start && !bus.stop) |=> ack_reg)
      else $error("control byte not acknowledged");
   a_data_sub: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ram_we |-> $past(sub_hit))
      else $error("ram write from unselected subaddress");
   a_ptr_adv: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (dat_byte && !ptr_wrap) |=> ptr_reg == $past(ptr_reg) + 8'h01)
      else $error("data pointer did not advance");
   a_bank_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (op_bank && mux_hi) |=> $stable(bank_reg))
      else $error("bank select taken in high multiplex");
   a_mode_load: assert property (@(posedge ref_clk) disable iff (!rst_b)
      op_mode |=> drive_mode == $past(b[1:0]) && bias_half == $past(b[2]))
      else $error("mode set not applied");
   a_devsel_load: assert property (@(posedge ref_clk) disable iff (!rst_b)
      op_devsel |=> sub_reg == $past(b[1:0]))
      else $error("device select not applied");
   a_only_ack_drive: assert property (@(posedge ref_clk) disable iff (!rst_b)
      sda_ack_oe |-> bus.ack_slot && !sda_ack_out)
      else $error("bus driven outside ack slot");
   a_ack_scl_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(sda_ack_oe) |-> !scl_in)
      else $error("ack driven while scl high");
endmodule // lcdp_top

//--- lcdp_master_model.sv
// partner: behavioural two-wire bus master, scl and open-drain sda
`timescale 1ns/1ns
module lcdp_master_model (
   // clock
   input  wire logic ref_clk,
   // bus lines, 1 means released to the pull-up
   output logic      scl_drv,
   output logic      sda_drv,
   input  wire logic sda_wire
);
   // ====================
   // bus timing
   int unsigned hc = 4; // half period in ref_clk cycles, 3 at least
   initial begin
      scl_drv = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic wt(input int unsigned n);
      repeat (n) @(posedge ref_clk);
   endtask
   // both lines go high first, so this serves as a repeated start too
   task automatic start_cond();
      sda_drv <= 1'b1;
      wt(hc);
      scl_drv <= 1'b1;
      wt(hc);
      sda_drv <= 1'b0;
      wt(hc);
      scl_drv <= 1'b0;
      wt(2);
   endtask
   task automatic stop_cond();
      sda_drv <= 1'b0;
      wt(hc);
      scl_drv <= 1'b1;
      wt(hc);
      sda_drv <= 1'b1;
      wt(hc);
   endtask
   // sda only moves two cycles after scl falls, never near a high phase
   task automatic send_byte(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_drv <= d[i];
         wt(hc);
         scl_drv <= 1'b1;
         wt(hc);
         scl_drv <= 1'b0;
         wt(2);
      end
      sda_drv <= 1'b1;
      wt(hc);
      scl_drv <= 1'b1;
      wt(hc - 1);
      ack = (sda_wire === 1'b0);
      wt(1);
      scl_drv <= 1'b0;
      wt(2);
   endtask
endmodule // lcdp_master_model

//--- lcd_driver_i2c_command_port_tb_top.sv
// testbench: random and corner command and display streams through the port
`timescale 1ns/1ns
module lcd_driver_i2c_command_port_tb_top;
   import lcdp_pkg::*;
   // ====================
   // signals and expectations
   logic        ref_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        addr_lsb_strap = 1'b0;
   logic        subaddr_strap_bit0 = 1'b0;
   logic        subaddr_strap_bit1 = 1'b0;
   logic        scl_drv, sda_drv, sda_ack_out, sda_ack_oe, ack;
   logic        display_enable, clk_out_enable, bias_half, ram_we;
   logic [1:0]  drive_mode, subaddr_count, bank_sel, exp_sub, exp_bank;
   logic [2:0]  blink_sel, presc_sel, exp_blink, exp_presc;
   logic [3:0]  exp_mode;
   logic [7:0]  data_pointer, ram_addr, ram_data, exp_ptr;
   logic [15:0] exp_q[$], got_q[$];
   logic [7:0]  corner[6] = '{8'hC1, 8'hFB, 8'hC0, 8'hF8, 8'h09, 8'h4E};
   logic [7:0]  junk[4] = '{8'h00, 8'hCF, 8'h40, 8'h55};
   wire         sda_wire;
   int          n_tests = 0;
   int          n_mismatch = 0;
   assign sda_wire = (sda_ack_oe === 1'b1) ? (sda_drv & sda_ack_out) : sda_drv;
   always #25 ref_clk = ~ref_clk;
   lcdp_top u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl_drv), .sda_in(sda_wire),
      .sda_ack_out(sda_ack_out), .sda_ack_oe(sda_ack_oe), .addr_lsb_strap(addr_lsb_strap),
      .subaddr_strap_bit0(subaddr_strap_bit0), .subaddr_strap_bit1(subaddr_strap_bit1),
      .display_enable(display_enable), .clk_out_enable(clk_out_enable),
      .bias_half(bias_half), .drive_mode(drive_mode), .data_pointer(data_pointer),
      .subaddr_count(subaddr_count), .bank_sel(bank_sel), .blink_sel(blink_sel),
      .presc_sel(presc_sel), .ram_we(ram_we), .ram_addr(ram_addr), .ram_data(ram_data));
   lcdp_master_model u_mst (.ref_clk(ref_clk), .scl_drv(scl_drv), .sda_drv(sda_drv),
      .sda_wire(sda_wire));
   always @(posedge ref_clk) begin
      if (ram_we === 1'b1) begin
         got_q.push_back({ram_addr, ram_data});
      end
   end
   // ====================
   // expectation helpers and bus tasks
   function automatic void apply_cmd(input logic [7:0] c);
      if (c[7:4] == 4'hC) exp_mode = c[3:0];
      else if (c[7:4] == 4'h0) exp_ptr[7:4] = c[3:0];
      else if (c[7:4] == 4'h4) exp_ptr[3:0] = c[3:0];
      else if (c[7:2] == 6'h38) exp_sub = c[1:0];
      else if (c[7:2] == 6'h3E && exp_mode[1:0] inside {2'h1, 2'h2}) exp_bank = c[1:0];
      else if (c[7:3] == 5'h1E) exp_blink = c[2:0];
      else if (c[7:3] == 5'h1D) exp_presc = c[2:0];
   endfunction
   function automatic logic [7:0] rnd_cmd(input int k);
      logic [7:0] r;
      r = 8'($urandom);
      case (k % 8)
         0: return {4'hC, r[3:0]};
         1: return {4'h0, 4'(r % 8'hA)};
         2: return {4'h4, r[3:0]};
         3: return {6'h38, r[1:0]};
         4: return {6'h3E, r[1:0]};
         5: return {5'h1E, r[2:0]};
         6: return {5'h1D, r[2:0]};
         default: return {4'h1, r[3:0]};
      endcase
   endfunction
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic open_wr(input logic lsb, input logic rd, input logic want);
      u_mst.start_cond();
      u_mst.send_byte({6'h1C, lsb, rd}, ack);
      chk("address ack", want, ack);
   endtask
   task automatic ctrl(input logic [7:0] b);
      u_mst.send_byte(b, ack);
      chk("control ack", 1'b1, ack);
   endtask
   task automatic cmd(input logic [7:0] b);
      u_mst.send_byte(b, ack);
      chk("command ack", 1'b1, ack);
      apply_cmd(b);
   endtask
   // a byte for another subaddress is refused but still moves the pointer
   task automatic disp(input logic [7:0] d);
      logic hit;
      hit = (exp_sub === {subaddr_strap_bit1, subaddr_strap_bit0});
      u_mst.send_byte(d, ack);
      chk("display ack", hit, ack);
      if (hit) exp_q.push_back({exp_ptr, d});
      if (exp_ptr == 8'h9F) begin
         exp_sub = exp_sub + 2'h1;
         exp_ptr = 8'h00;
      end else begin
         exp_ptr = exp_ptr + 8'h01;
      end
   endtask
   task automatic cfg_chk();
      chk("mode", exp_mode, {display_enable, bias_half, drive_mode});
      chk("clock out", exp_mode[3], clk_out_enable);
      chk("pointer", exp_ptr, data_pointer);
      chk("subaddress", exp_sub, subaddr_count);
      chk("bank", exp_bank, bank_sel);
      chk("blink", exp_blink, blink_sel);
      chk("prescaler", exp_presc, presc_sel);
      chk("ram write count", 16'(exp_q.size()), 16'(got_q.size()));
      while (exp_q.size() > 0 && got_q.size() > 0) begin
         chk("ram write", exp_q.pop_front(), got_q.pop_front());
      end
      exp_q.delete();
      got_q.delete();
   endtask
   task automatic close_chk();
      u_mst.stop_cond();
      repeat (4) @(posedge ref_clk);
      cfg_chk();
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end
      else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ====================
   // sequence
   initial begin
      #(50 * 90000);
      n_mismatch++;
      $display("[FAIL] watchdog expected end seen hang");
      final_report();
   end
   initial begin
      void'($urandom(49));
      {exp_mode, exp_ptr, exp_sub, exp_bank, exp_blink, exp_presc} = 22'h000003;
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      cfg_chk();
      // bank-select gating and pointer wrap into the next subaddress
      open_wr(1'b0, 1'b0, 1'b1);
      foreach (corner[k]) begin
         ctrl(8'h80);
         cmd(corner[k]);
      end
      ctrl(8'h40);
      repeat (4) disp(8'($urandom));
      close_chk();
      for (int i = 0; i < 16; i++) begin
         addr_lsb_strap <= 1'($urandom);
         {subaddr_strap_bit1, subaddr_strap_bit0} <= 2'($urandom);
         u_mst.hc = (i < 8) ? 4 : 7;
         @(posedge ref_clk);
         open_wr(addr_lsb_strap, 1'b0, 1'b1);
         for (int j = 0; j < 4; j++) begin
            ctrl(8'h80);
            cmd(rnd_cmd(i + j));
         end
         ctrl(8'hC0);
         disp(8'($urandom));
         ctrl(8'h00);
         cmd(rnd_cmd(i + 4));
         cmd(rnd_cmd(i + 5));
         open_wr(addr_lsb_strap, 1'b0, 1'b1);
         ctrl(8'h40);
         for (int j = 0; j < 3 + i % 3; j++) disp(8'($urandom));
         close_chk();
      end
      // other address and a read: each ignored until the next start or stop
      open_wr(~addr_lsb_strap, 1'b0, 1'b0);
      foreach (junk[k]) begin
         u_mst.send_byte(junk[k], ack);
         chk("ignored ack", 1'b0, ack);
      end
      open_wr(addr_lsb_strap, 1'b1, 1'b0);
      u_mst.send_byte(8'hCF, ack);
      chk("read ack", 1'b0, ack);
      close_chk();
      rst_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      {exp_mode, exp_ptr, exp_sub, exp_bank, exp_blink, exp_presc} = 22'h000003;
      @(posedge ref_clk);
      cfg_chk();
      final_report();
   end
endmodule // lcd_driver_i2c_command_port_tb_top
